/* hdl/cvm_pkg.sv */
package cvm_pkg;
	localparam int CHANNELS = 12;
	localparam int RESULT_W = 16;
	localparam int MODE_W = 3;
	localparam int MIN_BITS = 10;
	localparam logic [2:0] MODE_MAX = 3'h6;
	localparam int CLK_KHZ = 200000;
	localparam int SAMPLE_KHZ = 14000;
	localparam int PHASE_W = 18;
	localparam int DELAY_STEP_NS = 36600;
	localparam int DELAY_STEP_CYC = (DELAY_STEP_NS * (CLK_KHZ / 1000)) / 1000;
	localparam int DELAY_W = 5;
	localparam int FSR_MV = 5000;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DELAY,
		ST_MEASURE
	} meas_state_t;
endpackage

/* hdl/cvm_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module cvm_channel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Control
	input wire logic clear_i,
	input wire logic sample_en_i,
	input wire logic bit_i,
	input wire logic [2:0] mode_i,
	input wire logic latch_i,
	// Result
	output logic [15:0] result_o
);
	logic [16:0] acc_r, acc_nxt;
	logic [15:0] result_r, result_nxt;
	logic [16:0] full;
	logic [16:0] sat;

	always_comb begin
		full = 17'h00001 << (5'(cvm_pkg::MIN_BITS) + 5'(mode_i));
		acc_nxt = acc_r;
		if (clear_i) begin
			acc_nxt = 17'h00000;
		end else if (sample_en_i && bit_i) begin
			acc_nxt = acc_r + 17'h00001;
		end
		// The last sample lands in the latch cycle; all ones would reach 2^(10+mode), one past the largest code
		sat = (acc_nxt >= full) ? full - 17'h00001 : acc_nxt;
		result_nxt = result_r;
		if (latch_i) begin
			// Left aligned, unused low bits zero
			result_nxt = 16'(sat << (3'h6 - mode_i));
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			acc_r <= 17'h00000;
			result_r <= 16'h0000;
		end else begin
			acc_r <= acc_nxt;
			result_r <= result_nxt;
		end
	end

	assign result_o = result_r;
endmodule // cvm_channel
`default_nettype wire

/* hdl/cell_voltage_measure_ctrl.sv */
// Notes on behaviour
// - Start write launches all twelve channels together
// - Optional delay, 36.6 us steps, about 1.13 ms
// - Average whole window; restart discards accumulation
// - Start field self-clears when results are ready
// - Twelve per-cell result fields, index 0 to 11
// - Shared 3-bit mode selects 16 to 10 bits
// - Window is 2^bits samples at 14 MHz
// - Unsigned 16-bit results, unused low bits zero
// - Start cancels round robin, then delay applies
// - Round robin restarts after commanded measurement finishes
// - Measurement begins within 10 us of start, or of the delay's end when a delay is set
`timescale 1ns/1ps
`default_nettype none
module cell_voltage_measure_ctrl #(
	parameter int CHANNELS = cvm_pkg::CHANNELS,
	parameter int DELAY_STEP_CYC = cvm_pkg::DELAY_STEP_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Start command and configuration
	input wire logic start_i,
	input wire logic delay_en_i,
	input wire logic [cvm_pkg::DELAY_W-1:0] delay_steps_i,
	input wire logic [cvm_pkg::MODE_W-1:0] mode_i,
	// Modulator bitstreams, one per cell
	input wire logic [CHANNELS-1:0] mod_bits_i,
	// Status
	output logic start_busy_o,
	output logic meas_active_o,
	output logic [cvm_pkg::MODE_W-1:0] mode_used_o,
	// Round robin control
	output logic round_robin_task_cancel_o,
	output logic round_robin_task_restart_o,
	// Results, cell n at bits [16n+15:16n]
	output logic [CHANNELS*16-1:0] result_o
);
	localparam int DCNT_W = 24;

	cvm_pkg::meas_state_t state_r, state_nxt;
	logic busy_r, busy_nxt;
	logic cancel_r, cancel_nxt;
	logic restart_r, restart_nxt;
	logic meas_active_r, meas_active_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic [DCNT_W-1:0] dcnt_r, dcnt_nxt;
	logic [16:0] scnt_r, scnt_nxt;
	logic [cvm_pkg::PHASE_W-1:0] phase_r, phase_nxt;
	logic sample_en_r, sample_en_nxt;
	logic [CHANNELS-1:0] sync1_r, sync2_r;
	logic [CHANNELS-1:0] sync1_nxt, sync2_nxt;
	logic clear, latch;
	logic [2:0] mode_clamped;
	logic [DCNT_W-1:0] delay_total;
	logic [16:0] window;
	logic delay_wanted;
	logic ch_sample_en;
	logic [15:0] ch_result [CHANNELS];

	// Sample enable at 14 MHz on average via a phase accumulator; 200 is not a whole multiple
	always_comb begin
		phase_nxt = phase_r + cvm_pkg::PHASE_W'(cvm_pkg::SAMPLE_KHZ);
		sample_en_nxt = 1'b0;
		if (phase_nxt >= cvm_pkg::PHASE_W'(cvm_pkg::CLK_KHZ)) begin
			phase_nxt = phase_nxt - cvm_pkg::PHASE_W'(cvm_pkg::CLK_KHZ);
			sample_en_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			phase_r <= '0;
			sample_en_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			sample_en_r <= sample_en_nxt;
		end
	end

	// Two stages before any logic reads them; the modulator pins are not on this clock
	always_comb begin
		sync1_nxt = mod_bits_i;
		sync2_nxt = sync1_r;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// Code 111 has no defined width; treat it as full resolution
	assign mode_clamped = (mode_i > cvm_pkg::MODE_MAX) ? cvm_pkg::MODE_MAX : mode_i;
	assign delay_total = DCNT_W'(delay_steps_i) * DCNT_W'(DELAY_STEP_CYC);
	assign window = 17'h00001 << (5'(cvm_pkg::MIN_BITS) + 5'(mode_r));
	assign ch_sample_en = sample_en_r && state_r == cvm_pkg::ST_MEASURE;

	// Zero steps or a disabled timer both mean no wait
	always_comb begin
		delay_wanted = 1'b0;
		if (delay_en_i && delay_steps_i != '0) begin
			delay_wanted = 1'b1;
		end
	end

	always_comb begin
		state_nxt = state_r;
		busy_nxt = busy_r;
		mode_nxt = mode_r;
		dcnt_nxt = dcnt_r;
		scnt_nxt = scnt_r;
		cancel_nxt = 1'b0;
		restart_nxt = 1'b0;
		clear = 1'b0;
		latch = 1'b0;
		if (start_i) begin
			// Any start, even mid-measurement, throws away the partial sums
			busy_nxt = 1'b1;
			cancel_nxt = 1'b1;
			clear = 1'b1;
			scnt_nxt = 17'h00000;
			mode_nxt = mode_clamped;
			if (delay_wanted) begin
				state_nxt = cvm_pkg::ST_DELAY;
				dcnt_nxt = delay_total - DCNT_W'(1);
			end else begin
				state_nxt = cvm_pkg::ST_MEASURE;
			end
		end else begin
			unique case (state_r)
				cvm_pkg::ST_IDLE: begin
				end
				cvm_pkg::ST_DELAY: begin
					if (dcnt_r == '0) begin
						state_nxt = cvm_pkg::ST_MEASURE;
						clear = 1'b1;
					end else begin
						dcnt_nxt = dcnt_r - DCNT_W'(1);
					end
				end
				cvm_pkg::ST_MEASURE: begin
					if (sample_en_r) begin
						scnt_nxt = scnt_r + 17'h00001;
						// The final enable is counted by the channels in the same cycle it latches
						if (scnt_nxt == window) begin
							state_nxt = cvm_pkg::ST_IDLE;
							latch = 1'b1;
							busy_nxt = 1'b0;
							restart_nxt = 1'b1;
						end
					end
				end
			endcase
		end
		// Registered copy, so the status pin never comes from a state decoder
		meas_active_nxt = (state_nxt == cvm_pkg::ST_MEASURE);
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_r <= cvm_pkg::ST_IDLE;
			busy_r <= 1'b0;
			cancel_r <= 1'b0;
			restart_r <= 1'b0;
			meas_active_r <= 1'b0;
			mode_r <= cvm_pkg::MODE_MAX;
			dcnt_r <= '0;
			scnt_r <= 17'h00000;
		end else begin
			state_r <= state_nxt;
			busy_r <= busy_nxt;
			cancel_r <= cancel_nxt;
			restart_r <= restart_nxt;
			meas_active_r <= meas_active_nxt;
			mode_r <= mode_nxt;
			dcnt_r <= dcnt_nxt;
			scnt_r <= scnt_nxt;
		end
	end

	// One accumulator per cell, all sharing the same enable and window
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			cvm_channel u_ch (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.clear_i(clear),
				.sample_en_i(ch_sample_en),
				.bit_i(sync2_r[g]),
				.mode_i(mode_r),
				.latch_i(latch),
				.result_o(ch_result[g])
			);
		end
	endgenerate

	// Cell n occupies bits [16n+15:16n] of the result bus
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			result_o[i*16 +: 16] = ch_result[i];
		end
	end

	assign start_busy_o = busy_r;
	assign meas_active_o = meas_active_r;
	assign mode_used_o = mode_r;
	assign round_robin_task_cancel_o = cancel_r;
	assign round_robin_task_restart_o = restart_r;
endmodule // cell_voltage_measure_ctrl
`default_nettype wire

/* test/cvm_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module cvm_partner (
	input wire logic clk_i,
	input wire logic [11:0] lvl_i,
	output logic [11:0] bits_o
);
	// Steady levels keep the ones count exact despite the uneven sample rate
	always_ff @(posedge clk_i) bits_o <= lvl_i;
endmodule // cvm_partner
`default_nettype wire

/* test/cell_voltage_measure_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cvm_asserts #(parameter int CHANNELS = 12, parameter int DELAY_STEP_CYC = 4) (
	input wire logic clk_i, reset_n_i, start_i, delay_en_i, start_busy_o, meas_active_o,
	input wire logic round_robin_task_cancel_o, round_robin_task_restart_o,
	input wire logic [4:0] delay_steps_i,
	input wire logic [2:0] mode_i, mode_used_o,
	input wire logic [CHANNELS*16-1:0] result_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire cn = round_robin_task_cancel_o;
	wire rs = round_robin_task_restart_o;
	AST_CANCEL: assert property (start_i |=> cn && start_busy_o) else $error("no cancel");
	AST_CAUSE: assert property (cn |-> $past(start_i)) else $error("stray cancel");
	AST_RESTART: assert property (rs == $fell(start_busy_o)) else $error("bad restart");
	AST_MODE: assert property (start_i |=> mode_used_o == (&$past(mode_i) ? 3'h6 : $past(mode_i)))
		else $error("mode not taken");
	AST_LOWZ: assert property (rs |-> (result_o[15:0] & ~(16'hFFFF << (6 - mode_used_o))) == 0)
		else $error("low bits set");
	AST_HOLD: assert property ($changed(result_o) |-> rs) else $error("result moved");
	AST_NODLY: assert property (start_i && !(delay_en_i && |delay_steps_i) |=> meas_active_o [*2])
		else $error("late start");
	AST_DLY: assert property (start_i && delay_en_i && |delay_steps_i |=> !meas_active_o [*4])
		else $error("no delay");
	cover property (rs);
	cover property (start_i && start_busy_o);
	cover property (start_i && delay_en_i);
endmodule // cvm_asserts
bind cell_voltage_measure_ctrl cvm_asserts #(.CHANNELS(CHANNELS), .DELAY_STEP_CYC(DELAY_STEP_CYC)) u_cvm_asserts (
	.clk_i, .reset_n_i, .start_i, .delay_en_i, .start_busy_o, .meas_active_o, .round_robin_task_cancel_o,
	.round_robin_task_restart_o, .delay_steps_i, .mode_i, .mode_used_o, .result_o);
`default_nettype wire

/* test/cell_voltage_measure_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_voltage_measure_ctrl_bench;
	logic clk_i = 0, reset_n_i = 0, start_i = 0, delay_en_i = 0;
	logic [4:0] delay_steps_i = 0;
	logic [2:0] mode_i = 0, mode_used_o;
	logic [11:0] lvl = 0, mod_bits;
	logic start_busy_o, meas_active_o, cnl, rst;
	logic [191:0] result_o;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	initial forever #2.5 clk_i = ~clk_i;
	cvm_partner u_cvm_partner (.clk_i, .lvl_i(lvl), .bits_o(mod_bits));
	// Short delay step keeps the run small
	cell_voltage_measure_ctrl #(.DELAY_STEP_CYC(4)) u_cell_voltage_measure_ctrl (.clk_i, .reset_n_i, .start_i,
		.delay_en_i, .delay_steps_i, .mode_i, .mod_bits_i(mod_bits), .start_busy_o, .meas_active_o,
		.mode_used_o, .round_robin_task_cancel_o(cnl), .round_robin_task_restart_o(rst), .result_o);
	task chk(input logic [15:0] s, input logic [15:0] e, input string w);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", w, e, s);
		end
	endtask
	task print_verdict;
		if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	function logic [15:0] ex(input logic [2:0] m, input logic l);
		logic [16:0] s;
		s = l ? (17'h1 << (m + 10)) - 1 : 0;
		return 16'(s << (6 - m));
	endfunction
	function logic [15:0] mv(input logic [15:0] r);
		return 16'((32'(r) * cvm_pkg::FSR_MV) >> 16);
	endfunction
	task go(input logic [2:0] m, input logic de, input logic [4:0] ds);
		@(posedge clk_i);
		mode_i <= m;
		delay_en_i <= de;
		delay_steps_i <= ds;
		start_i <= 1;
		@(posedge clk_i);
		start_i <= 0;
	endtask
	task fin(input logic [2:0] m);
		int n;
		n = 0;
		while (start_busy_o !== 1'b0 && n < 40000) begin
			@(negedge clk_i);
			n++;
		end
		chk(start_busy_o, 0, "busy");
		for (int c = 0; c < 12; c++) begin
			chk(result_o[16*c+:16], ex(m, lvl[c]), "result");
			chk(mv(result_o[16*c+:16]), lvl[c] ? (m == 0 ? 16'h1383 : 16'h1385) : 16'h0000, "mv");
		end
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			print_verdict;
		end
	end
	initial begin
		int n;
		void'($urandom(44));
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1;
		for (int m = 7; m >= 0; m--) begin
			go(m, m[0], 0);
			@(negedge clk_i);
			chk(mode_used_o, m == 7 ? 6 : m, "mode");
		end
		@(posedge clk_i);
		lvl <= 12'($urandom);
		go(0, 0, 0);
		repeat (5000) @(posedge clk_i);
		lvl <= 12'($urandom);
		repeat (10) @(posedge clk_i);
		// Restart must throw away what the first level built up
		go(0, 0, 0);
		fin(0);
		@(posedge clk_i);
		lvl <= 12'($urandom);
		go(1, 1, 3);
		n = 0;
		while (meas_active_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk(n > 10 && n < 15, 1, "delay");
		fin(1);
		print_verdict;
	end
endmodule // cell_voltage_measure_ctrl_bench
`default_nettype wire
